// >>> tmx_pkg.sv
// constants, memory layouts and carriers of the conference mixer
// assumes one 10 MHz clock and a byte-wide register port
// Behaviour
// - each input channel gets its own 0/3/6/9 dB attenuation and noise gate
// - processed sample is expanded by the selected law into the sample buffer
// - sample stored at its slot index, added to its group's sum
// - output equals group sum minus the channel's own buffered sample
// - result compressed back to pcm, optional 3 dB output attenuation
// - channel parameter memory: 64 entries of 20 bits, any free slot usable
// - entry holds channel, in-atten, out-atten, noise level, invert, group
// - connection memory: 256 entries of 11 bits, one per output channel
// - transparent entry: mode, driver bit and 9-bit switched source
// - conference entry: mode, driver bit, 6-bit slot; other 3 bits ignored
// - law select 1 picks a-law, 0 picks mu-law, for all groups
// - byte format inverts none, even, odd or all pcm bits
// - overflowing result saturates, sets overflow flag, latches group number
// - group 31 channel is processed alone and sent to its own output
// - several entries may share one input channel, same or other groups
// - an entry without output still adds into its group sum
// - pending bit set after first byte, cleared within 900 ns of third
// - connection mode bit 1 is conference, 0 is transparent
// - output disable bit 0 drives the output, 1 leaves it off
`default_nettype none
package tmx_pkg;
    localparam int          NSLOT      = 64;
    localparam int          NCONF      = 21;
    localparam int          NOUT       = 256;
    localparam logic [4:0]  CONF_SOLO  = 5'h1f;
    localparam logic [1:0]  A_CFG      = 2'h0;
    localparam logic [1:0]  A_STAT     = 2'h1;
    localparam logic [1:0]  A_IND      = 2'h2;
    localparam logic [1:0]  A_PEND     = 2'h3;
    localparam int          CFG_EN     = 0;
    localparam int          CFG_LAW    = 1;
    localparam int          CFG_BF_LO  = 2;
    localparam int          CFG_BF_HI  = 3;
    localparam logic [7:0]  CFG_RST    = 8'h00;
    localparam int          STAT_OVF   = 7;
    localparam logic [2:0]  CMD_CCM1   = 3'h3;
    localparam logic [2:0]  CMD_CCM2   = 3'h5;
    localparam logic [2:0]  CMD_CM     = 3'h1;
    localparam logic [15:0] FS_MU      = 16'h7d7c;
    localparam logic [15:0] FS_A       = 16'h7e00;
    localparam logic [15:0] MU_BIAS    = 16'h0084;
    localparam logic [15:0] MU_CLIP    = 16'h7f7b;
    localparam logic [6:0]  NOI_T1     = 7'h05;
    localparam logic [6:0]  NOI_T2     = 7'h09;
    localparam logic [6:0]  NOI_T3     = 7'h10;

    typedef struct packed {
        logic [8:0] chan;
        logic [1:0] iat;
        logic       oat;
        logic [1:0] noi;
        logic       inv;
        logic [4:0] conf;
    } tmx_ccm_s;

    typedef struct packed {
        logic       mode;
        logic       output_disable;
        logic [8:0] src;
    } tmx_cm_s;

    typedef struct packed {
        logic [8:0] chan;
        logic [7:0] pcm;
    } tmx_in_s;

    typedef struct packed {
        logic [7:0] pcm;
        logic       oe;
        logic       conf;
        logic [8:0] src;
    } tmx_out_s;

    localparam tmx_ccm_s CCM_RST = '{9'h000, 2'h0, 1'b0, 2'h0, 1'b0, 5'h15};
    localparam tmx_cm_s  CM_RST  = '{1'b0, 1'b1, 9'h000};
endpackage
`default_nettype wire

// >>> tmx_conf_mixer.sv
// conference datapath: input processing, group sums, subtraction, output
// assumes samples arrive one at a time between frame_sync pulses
`timescale 1ns/1ps
`default_nettype none
module tmx_conf_mixer (
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    input  wire logic [1:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    input  wire logic               frame_sync,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire tmx_pkg::tmx_in_s   in_data,
    input  wire logic               out_req,
    input  wire logic [7:0]         out_chan,
    output logic                    out_valid,
    output tmx_pkg::tmx_out_s       out_data
);
    import tmx_pkg::*;

    typedef enum logic [2:0] {
        IND_IDLE = 3'b001,
        IND_CTL  = 3'b010,
        IND_DAT  = 3'b100
    } tmx_ind_e;

    tmx_ccm_s             ccm_reg [NSLOT];
    tmx_cm_s              cm_reg [NOUT];
    logic signed [15:0]   dm_reg [2][NSLOT];
    logic signed [21:0]   csm_reg [2][NCONF];
    logic                 bank_reg;
    logic [7:0]           cfg_reg;
    logic                 ovf_reg;
    logic [4:0]           grp_reg;
    tmx_ind_e             ind_reg;
    logic [7:0]           ctl_reg;
    logic [7:0]           dat_reg;
    tmx_in_s              smp_reg;
    logic [NSLOT-1:0]     mask_reg;
    logic                 commit;
    logic [7:0]           bfmask;
    logic                 alaw;

    function automatic logic signed [15:0] expand(input logic [7:0] c,
                                                  input logic       al);
        logic [15:0] m;
        logic [2:0]  e;
        e = c[6:4];
        if (al) begin
            if (e == 3'h0)
                m = {8'h00, c[3:0], 4'h8};
            else
                m = ({8'h00, c[3:0], 4'h0} + 16'h0108) << (e - 3'h1);
        end else begin
            m = (({9'h000, c[3:0], 3'h0} + MU_BIAS) << e) - MU_BIAS;
        end
        expand = c[7] ? $signed(m) : -$signed(m);
    endfunction

    function automatic logic [7:0] compress(input logic signed [15:0] v,
                                            input logic              al);
        logic [15:0] a;
        logic [2:0]  e;
        logic [3:0]  m;
        a = v[15] ? 16'(-v) : 16'(v);
        e = 3'h0;
        if (!al) begin
            if (a > MU_CLIP)
                a = MU_CLIP;
            a = a + MU_BIAS;
        end
        for (int i = 1; i < 8; i++) begin
            if (a[i+7])
                e = 3'(i);
        end
        if (al && e == 3'h0)
            m = a[7:4];
        else
            m = 4'(a >> ({1'b0, e} + 4'h3));
        compress = {~v[15], e, m};
    endfunction

    // shift-add near 0.707; cheaper than a multiplier, error under 0.1 dB
    function automatic logic signed [21:0] att3(input logic signed [21:0] x);
        att3 = (x >>> 1) + (x >>> 3) + (x >>> 4) + (x >>> 6);
    endfunction

    assign alaw = cfg_reg[CFG_LAW];
    always_comb begin
        case ({cfg_reg[CFG_BF_HI], cfg_reg[CFG_BF_LO]})
            2'b00:   bfmask = 8'h00;
            2'b01:   bfmask = 8'h55;
            2'b10:   bfmask = 8'haa;
            default: bfmask = 8'hff;
        endcase
    end

    // indirect port: three bytes per access
    assign commit = reg_wr && reg_addr == A_IND && ind_reg == IND_DAT;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ind_reg <= IND_IDLE;
            ctl_reg <= 8'h00;
            dat_reg <= 8'h00;
        end else if (reg_wr && reg_addr == A_IND) begin
            case (ind_reg)
                IND_IDLE: begin
                    ctl_reg <= reg_wdata;
                    ind_reg <= IND_CTL;
                end
                IND_CTL: begin
                    dat_reg <= reg_wdata;
                    ind_reg <= IND_DAT;
                end
                IND_DAT: ind_reg <= IND_IDLE;
                default: ind_reg <= IND_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NSLOT; i++)
                ccm_reg[i] <= CCM_RST;
        end else if (commit) begin
            if (ctl_reg[7:5] == CMD_CCM1) begin
                ccm_reg[reg_wdata[5:0]].chan <= {ctl_reg[0], dat_reg};
                ccm_reg[reg_wdata[5:0]].inv  <= ctl_reg[1];
            end else if (ctl_reg[7:5] == CMD_CCM2) begin
                ccm_reg[reg_wdata[5:0]].noi  <= ctl_reg[1:0];
                ccm_reg[reg_wdata[5:0]].iat  <= dat_reg[7:6];
                ccm_reg[reg_wdata[5:0]].oat  <= dat_reg[5];
                ccm_reg[reg_wdata[5:0]].conf <= dat_reg[4:0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NOUT; i++)
                cm_reg[i] <= CM_RST;
        end else if (commit && ctl_reg[7:5] == CMD_CM) begin
            cm_reg[reg_wdata] <= '{ctl_reg[2], ctl_reg[1],
                                   {ctl_reg[0], dat_reg}};
        end
    end

    // input side: one matching slot handled per cycle
    logic [5:0]          pidx;
    tmx_ccm_s            pent;
    logic [7:0]          ppcm;
    logic [6:0]          pthr;
    logic signed [21:0]  plin;
    logic signed [21:0]  patt;
    logic [NSLOT-1:0]    match;

    assign in_ready = mask_reg == '0 && !frame_sync;
    always_comb begin
        pidx = 6'h00;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (mask_reg[i])
                pidx = 6'(i);
        end
        for (int i = 0; i < NSLOT; i++)
            match[i] = ccm_reg[i].chan == in_data.chan;
    end

    assign pent = ccm_reg[pidx];
    assign ppcm = smp_reg.pcm ^ bfmask ^ {8{pent.inv}};
    always_comb begin
        case (pent.noi)
            2'h0:    pthr = 7'h00;
            2'h1:    pthr = NOI_T1;
            2'h2:    pthr = NOI_T2;
            default: pthr = NOI_T3;
        endcase
        // gate on the code before expansion, attenuate right after it
        if (ppcm[6:0] < pthr)
            plin = 22'sh0;
        else
            plin = 22'(expand(ppcm, alaw));
        case (pent.iat)
            2'h0:    patt = plin;
            2'h1:    patt = att3(plin);
            2'h2:    patt = plin >>> 1;
            default: patt = att3(plin >>> 1);
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= '0;
            smp_reg  <= '0;
        end else if (in_valid && in_ready) begin
            mask_reg <= match;
            smp_reg  <= in_data;
        end else if (mask_reg != '0) begin
            mask_reg[pidx] <= 1'b0;
        end
    end

    // two banks: the frame being built and the frame being read
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            bank_reg <= 1'b0;
        else if (frame_sync)
            bank_reg <= ~bank_reg;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < 2; b++)
                for (int i = 0; i < NSLOT; i++)
                    dm_reg[b][i] <= 16'sh0;
        end else if (mask_reg != '0) begin
            dm_reg[bank_reg][pidx] <= 16'(patt);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < 2; b++)
                for (int i = 0; i < NCONF; i++)
                    csm_reg[b][i] <= 22'sh0;
        end else begin
            if (frame_sync)
                for (int i = 0; i < NCONF; i++)
                    csm_reg[~bank_reg][i] <= 22'sh0;
            // no output needed: tone slots add in here too
            if (mask_reg != '0 && cfg_reg[CFG_EN] && pent.conf < NCONF)
                csm_reg[bank_reg][pent.conf] <=
                    csm_reg[bank_reg][pent.conf] + patt;
        end
    end

    // output side: looked up on request, answered next cycle
    tmx_cm_s             oent;
    tmx_ccm_s            oprm;
    logic signed [21:0]  oown;
    logic signed [21:0]  odif;
    logic signed [21:0]  ofs;
    logic signed [21:0]  osat;
    logic signed [21:0]  ofin;
    logic                oovf;
    logic                oconf;
    tmx_out_s            onext;

    assign oent  = cm_reg[out_chan];
    assign oprm  = ccm_reg[oent.src[5:0]];
    assign oown  = 22'(dm_reg[~bank_reg][oent.src[5:0]]);
    assign oconf = oent.mode && cfg_reg[CFG_EN];
    assign ofs   = alaw ? 22'(FS_A) : 22'(FS_MU);
    always_comb begin
        if (oprm.conf == CONF_SOLO)
            odif = oown;
        else if (oprm.conf < NCONF)
            odif = csm_reg[~bank_reg][oprm.conf] - oown;
        else
            odif = 22'sh0;
        oovf = 1'b0;
        osat = odif;
        if (odif > ofs) begin
            osat = ofs;
            oovf = 1'b1;
        end else if (odif < -ofs) begin
            osat = -ofs;
            oovf = 1'b1;
        end
        ofin = oprm.oat ? att3(osat) : osat;
        onext.pcm  = oconf ? compress(16'(ofin), alaw) ^ bfmask
                           : compress(16'sh0, alaw) ^ bfmask;
        onext.oe   = !oent.output_disable;
        onext.conf = oent.mode;
        onext.src  = oent.src;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_data  <= '{8'h00, 1'b0, 1'b0, 9'h000};
        end else begin
            out_valid <= out_req;
            if (out_req)
                out_data <= onext;
        end
    end

    // registers; overflow clears on status read, a new event wins
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            cfg_reg <= CFG_RST;
        else if (reg_wr && reg_addr == A_CFG)
            cfg_reg <= reg_wdata;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_reg <= 1'b0;
            grp_reg <= 5'h00;
        end else if (out_req && oconf && oovf
                     && oprm.conf < NCONF) begin
            ovf_reg <= 1'b1;
            grp_reg <= oprm.conf;
        end else if (reg_rd && reg_addr == A_STAT) begin
            ovf_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                A_CFG:   reg_rdata <= cfg_reg;
                A_STAT:  reg_rdata <= {ovf_reg, 2'b00, grp_reg};
                A_PEND:  reg_rdata <= {7'h00, ind_reg != IND_IDLE};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> tmx_assertions.sv
// port assertions of the conference mixer
// assumes it is bound into tmx_conf_mixer and sees every host write
`timescale 1ns/1ps
`default_nettype none
module tmx_assertions (
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    input wire logic [1:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              frame_sync,
    input wire logic              in_valid,
    input wire logic              in_ready,
    input wire tmx_pkg::tmx_in_s  in_data,
    input wire logic              out_req,
    input wire logic [7:0]        out_chan,
    input wire logic              out_valid,
    input wire tmx_pkg::tmx_out_s out_data
);
    import tmx_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic [1:0]  idx_reg;
    logic [7:0]  ctl_reg;
    logic [7:0]  dat_reg;
    logic [3:0]  cfg_reg;
    logic [10:0] cm_reg [NOUT];
    wire         ind_wr = reg_wr && reg_addr == A_IND;
    wire         rd_st  = reg_rd && reg_addr == A_STAT;
    wire         pend_w = idx_reg != 2'h0;
    wire [10:0]  cm_w   = cm_reg[out_chan];
    wire         dis_w  = cm_w[9];
    wire         mode_w = cm_w[10];
    // shadow of indirect traffic; an aborted sequence is not modelled
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            idx_reg <= 2'h0;
            cfg_reg <= 4'h0;
        end else begin
            if (ind_wr) idx_reg <= (idx_reg == 2'h2) ? 2'h0 : idx_reg + 2'h1;
            if (reg_wr && reg_addr == A_CFG) cfg_reg <= reg_wdata[3:0];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (ind_wr && idx_reg == 2'h0) ctl_reg <= reg_wdata;
        if (ind_wr && idx_reg == 2'h1) dat_reg <= reg_wdata;
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NOUT; i++) cm_reg[i] <= CM_RST;
        end else if (ind_wr && idx_reg == 2'h2 && ctl_reg[7:5] == CMD_CM) begin
            cm_reg[reg_wdata] <= {ctl_reg[2:0], dat_reg};
        end
    end
    chk_pend_state: assert property (reg_rd && reg_addr == A_PEND
        |=> reg_rdata[0] == $past(pend_w)) else $error("pending bit wrong");
    chk_pend_clear: assert property (ind_wr && idx_reg == 2'h2
        ##[1:2] reg_rd && reg_addr == A_PEND |=> !reg_rdata[0])
        else $error("pending not cleared");
    chk_cfg_read: assert property (reg_rd && reg_addr == A_CFG
        |=> reg_rdata[3:0] == $past(cfg_reg)) else $error("cfg readback");
    chk_cm_mode: assert property (out_req
        |=> out_data.conf == $past(mode_w)) else $error("mode bit ignored");
    chk_cm_driver: assert property (out_req
        |=> out_data.oe == !$past(dis_w)) else $error("driver bit ignored");
    chk_cm_source: assert property (out_req && !mode_w
        |=> out_data.src == $past(cm_w[8:0])) else $error("source wrong");
    chk_out_timing: assert property (out_req |=> out_valid)
        else $error("output late");
    chk_out_hold: assert property (!out_req |=> $stable(out_data))
        else $error("output moved");
    chk_frame_block: assert property (frame_sync |-> !in_ready)
        else $error("ready during frame start");
    // at most one cycle per parameter slot before the next sample is taken
    chk_ready_back: assert property (in_valid && in_ready
        |=> ##[0:64] in_ready) else $error("input stalled");
    chk_ovf_clear: assert property (rd_st && !out_req ##1 !out_req
        ##1 rd_st && !out_req |=> !reg_rdata[STAT_OVF])
        else $error("overflow not cleared");
    cover property (out_valid && out_data.conf);
    cover property (rd_st ##1 reg_rdata[STAT_OVF]);
    cover property (in_valid && in_ready ##1 !in_ready);
endmodule
`default_nettype wire

// >>> tmx_pcm_source.sv
// highway sample source facing the mixer input stream
// assumes the bench pulses send for one cycle per sample
`timescale 1ns/1ps
`default_nettype none
module tmx_pcm_source (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             send,
    input  wire tmx_pkg::tmx_in_s send_data,
    input  wire logic             in_ready,
    output logic                  in_valid,
    output tmx_pkg::tmx_in_s      in_data
);
    import tmx_pkg::*;
    // sample held until taken; idle lines toggle so stale data never matches
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            in_valid <= 1'b0;
            in_data  <= '0;
        end else if (send) begin
            in_valid <= 1'b1;
            in_data  <= send_data;
        end else begin
            if (in_valid && in_ready) in_valid <= 1'b0;
            if (!in_valid || in_ready) in_data <= ~in_data;
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench of the conference mixer
// assumes tmx_pkg, tmx_pcm_source and tmx_assertions compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tmx_pkg::*;
    logic       clk_sys = 1'b0, sys_rst = 1'b0, reg_wr = 1'b0;
    logic       reg_rd = 1'b0, frame_sync = 1'b0, out_req = 1'b0;
    logic       send = 1'b0, in_valid, in_ready, out_valid;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, out_chan = 8'h00, reg_rdata, q, p, r;
    logic [8:0] s9;
    tmx_in_s    in_data, send_data = '0;
    tmx_out_s   out_data, o;
    int         mismatches = 0, tests_run = 0, cycles = 0, seed = 32'h9a06;
    tmx_conf_mixer dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_sync(frame_sync),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .out_req(out_req), .out_chan(out_chan), .out_valid(out_valid),
        .out_data(out_data));
    tmx_pcm_source src (.clk_sys(clk_sys), .sys_rst(sys_rst), .send(send),
        .send_data(send_data), .in_ready(in_ready), .in_valid(in_valid),
        .in_data(in_data));
    always #50 clk_sys = ~clk_sys;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // silence stands for gated input and for mu-law negative zero
    function automatic logic [7:0] exp_code(input logic [7:0] c,
            input logic law, input logic [1:0] f, input logic gate);
        if (gate || (!law && (c ^ {4{f}}) == 8'h00)) return 8'h80 ^ {4{f}};
        return c;
    endfunction
    task automatic bus(input logic w, input logic [1:0] a,
            input logic [7:0] d, output logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic ind(input logic [7:0] c, d, a);
        logic [7:0] v;
        bus(1'b1, A_IND, c, v);
        bus(1'b0, A_PEND, 8'h00, v);
        chk("pending set", v[0], 1'b1);
        bus(1'b1, A_IND, d, v);
        bus(1'b1, A_IND, a, v);
        bus(1'b0, A_PEND, 8'h00, v);
        chk("pending clear", v[0], 1'b0);
    endtask
    task automatic prog(input logic [5:0] s, input logic [8:0] ch,
            input logic [4:0] g, input logic [1:0] n);
        ind({CMD_CCM1, 4'h0, ch[8]}, ch[7:0], {2'h0, s});
        ind({CMD_CCM2, 3'h0, n}, {3'h0, g}, {2'h0, s});
    endtask
    task automatic cmw(input logic [7:0] a, input logic m, d,
            input logic [8:0] sv);
        ind({CMD_CM, 2'h0, m, d, sv[8]}, sv[7:0], a);
    endtask
    task automatic smp(input logic [8:0] c, input logic [7:0] v);
        @(posedge clk_sys);
        send <= 1'b1;
        send_data <= {c, v};
        @(posedge clk_sys);
        send <= 1'b0;
        for (int i = 0; i < 70; i++) begin
            @(posedge clk_sys);
            #1;
            if (!in_valid && in_ready) break;
        end
    endtask
    task automatic frm;
        @(posedge clk_sys);
        frame_sync <= 1'b1;
        @(posedge clk_sys);
        frame_sync <= 1'b0;
    endtask
    task automatic outq(input logic [7:0] c, output tmx_out_s d);
        @(posedge clk_sys);
        out_req <= 1'b1;
        out_chan <= c;
        @(posedge clk_sys);
        out_req <= 1'b0;
        #1;
        chk("out valid", out_valid, 1'b1);
        d = out_data;
    endtask
    initial begin
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            bus(1'b0, 2'(a), 8'h00, q);
            chk("reset reg", q, 8'h00);
        end
        $display("test reset done");
        prog(6'd20, 9'h0a3, CONF_SOLO, 2'h0);
        cmw(8'd40, 1'b1, 1'b0, 9'd20);
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, A_CFG, {4'h0, 2'(m >> 1), m[0], 1'b1}, q);
            bus(1'b0, A_CFG, 8'h00, q);
            chk("cfg", q[3:0], {2'(m >> 1), m[0], 1'b1});
            p = 8'($random(seed));
            smp(9'h0a3, p);
            frm();
            outq(8'd40, o);
            chk("solo", o.pcm, exp_code(p, m[0], 2'(m >> 1), 1'b0));
            chk("solo oe", o.oe, 1'b1);
        end
        // a-law halving drops the exponent by one and keeps the mantissa
        bus(1'b1, A_CFG, 8'h03, q);
        ind({CMD_CCM1, 3'h0, 2'h2}, 8'ha3, 8'd20);
        ind({CMD_CCM2, 5'h00}, {2'h2, 1'b0, CONF_SOLO}, 8'd20);
        for (int k = 0; k < 6; k++) begin
            p = 8'($random(seed));
            p[6:4] = 3'h2 + 3'(k);
            smp(9'h0a3, ~p);
            frm();
            outq(8'd40, o);
            chk("inv 6db", o.pcm, {p[7], p[6:4] - 3'h1, p[3:0]});
        end
        bus(1'b1, A_CFG, 8'h01, q);
        prog(6'd20, 9'h0a3, CONF_SOLO, 2'h3);
        for (int k = 0; k < 2; k++) begin
            p = 8'h8f + 8'(k);
            smp(9'h0a3, p);
            frm();
            outq(8'd40, o);
            chk("gate", o.pcm, exp_code(p, 1'b0, 2'h0, k == 0));
        end
        $display("test solo done");
        prog(6'd2, 9'h00a, 5'h05, 2'h0);
        prog(6'd7, 9'h014, 5'h05, 2'h0);
        cmw(8'd0, 1'b1, 1'b0, 9'h1c2);
        cmw(8'd1, 1'b1, 1'b0, 9'd7);
        p = 8'($random(seed));
        r = 8'($random(seed));
        smp(9'h00a, p);
        smp(9'h014, r);
        frm();
        outq(8'd0, o);
        chk("minus own a", o.pcm, exp_code(r, 1'b0, 2'h0, 1'b0));
        outq(8'd1, o);
        chk("minus own b", o.pcm, exp_code(p, 1'b0, 2'h0, 1'b0));
        $display("test conference done");
        prog(6'd9, 9'h00a, 5'h05, 2'h0);
        for (int k = 0; k < 2; k++) begin
            p = k ? 8'h7f : 8'hff;
            smp(9'h00a, p);
            smp(9'h014, 8'h80);
            frm();
            outq(8'd1, o);
            chk("saturate", o.pcm, p);
            bus(1'b0, A_STAT, 8'h00, q);
            chk("ovf status", q, {1'b1, 2'h0, 5'h05});
            bus(1'b0, A_STAT, 8'h00, q);
            chk("ovf clear", q[STAT_OVF], 1'b0);
        end
        $display("test overflow done");
        for (int k = 0; k < 4; k++) begin
            s9 = 9'($random(seed));
            cmw(8'd100, k[1], k[0], s9);
            outq(8'd100, o);
            chk("mode", o.conf, k[1]);
            chk("driver", o.oe, !k[0]);
            if (!k[1]) chk("source", o.src, s9);
        end
        prog(6'd7, 9'h014, 5'h15, 2'h0);
        cmw(8'd1, 1'b0, 1'b1, 9'h000);
        frm();
        outq(8'd1, o);
        chk("removed", o.oe, 1'b0);
        $display("test connection done");
        print_verdict();
    end
endmodule
bind tmx_conf_mixer tmx_assertions u_chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_sync(frame_sync), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_req(out_req), .out_chan(out_chan),
    .out_valid(out_valid), .out_data(out_data));
`default_nettype wire
